// *** bench/indexed_literal_offset_decode_tb.sv ***
`timescale 1ns/1ps
module indexed_literal_offset_decode_tb;
  import ilo_pkg::*;
  // One expected result; ret marks a subtract-and-return, otherwise a memory operand.
  typedef struct {
    logic              ret;
    logic [ADDR_W-1:0] addr;
    logic              idx;
    logic              dest;
    logic [PC_W-1:0]   pc;
    logic [ADDR_W-1:0] fp;
  } ilo_exp_t;

  logic sys_clk, rst_n, instr_ready, ext_enable, frame_wr_en, pc_load, flags_hold, nop_cycle;
  ilo_instr_t           instr;
  logic [BANK_W-1:0]    bank_select_pointer;
  logic [PC_W-1:0]      top_of_return_stack, pc_value;
  logic [ADDR_W-1:0]    frame_wr_data, stack_frame_pointer, fp;
  ilo_mem_t             mem;
  ilo_exp_t             q[$], nul, e;
  int                   errors, num_checks, seed, i;
  logic [31:0]          r;
  logic                 ret_seen = 1'b0;

  ilo_decode dut (.sys_clk(sys_clk), .rst_n(rst_n), .instr(instr), .instr_ready(instr_ready),
    .ext_enable(ext_enable), .bank_select_pointer(bank_select_pointer),
    .top_of_return_stack(top_of_return_stack), .frame_wr_en(frame_wr_en),
    .frame_wr_data(frame_wr_data), .stack_frame_pointer(stack_frame_pointer),
    .pc_load(pc_load), .pc_value(pc_value), .mem(mem), .flags_hold(flags_hold),
    .nop_cycle(nop_cycle));

  // The clock runs at 125 MHz.
  always #4 sys_clk = ~sys_clk;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Operand address as the access mode rules place it, from the bench's own frame pointer copy.
  function automatic ilo_exp_t mem_exp(logic [15:0] w, logic ext, logic [BANK_W-1:0] b);
    ilo_exp_t x;
    x = '{ret: 1'b0, addr: '0, idx: 1'b0, dest: 1'b0, pc: '0, fp: fp};
    x.idx = ext && !w[ACCESS_BIT] && (w[7:0] <= OFS_MAX);
    if (w[ACCESS_BIT]) x.addr = {b, w[7:0]};
    else if (x.idx) x.addr = fp + {4'h0, w[7:0]};
    else x.addr = {(w[7:0] > OFS_MAX) ? ACC_HI_BANK : ACC_LO_BANK, w[7:0]};
    x.dest = (w[15:12] <= 4'h6) ? w[DEST_BIT] : 1'b0;
    return x;
  endfunction

  // Holds the word until a negedge shows ready, so refused words are offered again.
  task automatic send(input logic [15:0] w, input logic ext, input logic [BANK_W-1:0] b,
                      input logic push, input ilo_exp_t x);
    instr <= '{word: w, valid: 1'b1};
    ext_enable <= ext;
    bank_select_pointer <= b;
    @(negedge sys_clk);
    while (instr_ready !== 1'b1) @(negedge sys_clk);
    @(posedge sys_clk);
    if (push) q.push_back(x);
  endtask

  task automatic mop(input logic [15:0] w, input logic ext, input logic [BANK_W-1:0] b);
    send(w, ext, b, 1'b1, mem_exp(w, ext, b));
  endtask

  task automatic ret(input logic [5:0] k);
    logic [PC_W-1:0] t;
    t = PC_W'($random(seed));
    top_of_return_stack <= t;
    fp = fp - {6'h0, k};
    send({SUB_PTR_OPC, SEL_RETURN, k}, 1'b1, 4'h0, 1'b1,
         '{ret: 1'b1, addr: '0, idx: 1'b0, dest: 1'b0, pc: t, fp: fp});
  endtask

  // Select 11 is the return form, so it must be noted as a return and not sent silently.
  task automatic sub(input logic [1:0] s, input logic [5:0] k);
    if (s == SEL_RETURN) ret(k);
    else begin
      if (s == SEL_FRAME) fp = fp - {6'h0, k};
      send({SUB_PTR_OPC, s, k}, 1'b0, 4'h0, 1'b0, nul);
    end
  endtask

  task automatic wrfp(input logic [ADDR_W-1:0] v);
    instr.valid <= 1'b0;
    frame_wr_en <= 1'b1;
    frame_wr_data <= v;
    @(posedge sys_clk);
    frame_wr_en <= 1'b0;
    fp = v;
    @(posedge sys_clk);
  endtask

  // Watches the outputs and compares each result with the oldest note in the queue.
  always @(negedge sys_clk) begin
    if (ret_seen) begin
      check("flags_hold second cycle", flags_hold, 1);
      check("nop_cycle second cycle", nop_cycle, 0);
    end
    ret_seen = 1'b0;
    if (rst_n === 1'b1 && (pc_load === 1'b1 || mem.addr_valid === 1'b1)) begin
      if (q.size() == 0) check("unexpected result", 1, 0);
      else begin
        e = q.pop_front();
        check("stack_frame_pointer", stack_frame_pointer, e.fp);
        check("pc_load", pc_load, e.ret);
        check("flags_hold", flags_hold, e.ret);
        check("nop_cycle", nop_cycle, e.ret);
        check("instr_ready", instr_ready, !e.ret);
        check("mem.addr_valid", mem.addr_valid, !e.ret);
        if (e.ret) check("pc_value", pc_value, e.pc);
        else begin
          check("mem.addr", mem.addr, e.addr);
          check("mem.indexed", mem.indexed, e.idx);
          check("mem.dest_f", mem.dest_f, e.dest);
        end
        ret_seen = e.ret;
      end
    end
  end

  // A run takes a few hundred cycles; this limit of 25000 cycles is many times that.
  initial begin
    #200000;
    errors++;
    give_verdict();
  end

  initial begin
    seed = 32'hb08f;
    sys_clk = 1'b0;
    rst_n = 1'b0;
    instr = '0;
    {ext_enable, frame_wr_en, bank_select_pointer} = '0;
    top_of_return_stack = '0;
    frame_wr_data = '0;
    fp = '0;
    repeat (4) @(posedge sys_clk);
    check("frame pointer at reset", stack_frame_pointer, FRAME_RST);
    rst_n <= 1'b1;
    wrfp(12'h3ff);
    ret(6'h23);
    mop(16'h2605, 1'b1, 4'h2);
    mop(16'h245f, 1'b1, 4'h2);
    mop(16'h2660, 1'b1, 4'h2);
    mop(16'h2720, 1'b1, 4'h5);
    wrfp(12'h000);
    mop(16'h2620, 1'b1, 4'h0);
    mop(16'h2620, 1'b0, 4'h0);
    // The two low-opcode byte groups are decoded too and need words of their own.
    mop(16'h0605, 1'b1, 4'h0);
    mop(16'h0230, 1'b1, 4'h0);
    ret(6'h3f);
    ret(6'h00);
    for (i = 0; i < 300; i++) begin
      r = $random(seed);
      case (r[3:0])
        4'h0: ret(r[9:4]);
        4'h1: sub(r[5:4], r[11:6]);
        4'h2: wrfp(r[27:16]);
        default: mop({4'h1 + 4'(r[7:4] % 11), r[19:8]}, r[20], r[24:21]);
      endcase
    end
    instr.valid <= 1'b0;
    repeat (3) @(posedge sys_clk);
    // A second reset in mid-run must restore the idle state and a zero frame pointer.
    rst_n <= 1'b0;
    @(posedge sys_clk);
    check("stack_frame_pointer at reset", stack_frame_pointer, FRAME_RST);
    check("pc_value at reset", pc_value, PC_RST);
    check("instr_ready at reset", instr_ready, 1);
    check("nop_cycle at reset", nop_cycle, 0);
    check("addr_valid at reset", mem.addr_valid, 0);
    rst_n <= 1'b1;
    fp = FRAME_RST;
    mop(16'h2605, 1'b1, 4'h0);
    instr.valid <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check("results left over", q.size(), 0);
    give_verdict();
  end
endmodule // indexed_literal_offset_decode_tb

// *** hdl/ilo_addr_resolve.sv ***
`timescale 1ns/1ps
module ilo_addr_resolve
  import ilo_pkg::*;
(
  input  wire logic                 ext_enable,
  input  wire logic                 access_sel,
  input  wire logic [7:0]           file_addr,
  input  wire logic [BANK_W-1:0]    bank_select_pointer,
  input  wire logic [ADDR_W-1:0]    frame_ptr,
  output logic      [ADDR_W-1:0]    addr,
  output logic                      indexed
);
  // Picks banked, access or frame-relative addressing for one embedded file address.
  always_comb begin
    indexed = 1'b0;
    if (access_sel) begin
      addr = {bank_select_pointer, file_addr};
    end else if (file_addr <= OFS_MAX) begin
      if (ext_enable) begin
        // The sum wraps inside the data space, as a pointer increment would.
        addr    = frame_ptr + {ACC_LO_BANK, file_addr};
        indexed = 1'b1;
      end else begin
        addr = {ACC_LO_BANK, file_addr};
      end
    end else begin
      addr = {ACC_HI_BANK, file_addr};
    end
  end
endmodule // ilo_addr_resolve

// *** hdl/ilo_decode.sv ***
`timescale 1ns/1ps
module ilo_decode
  import ilo_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  input  wire ilo_pkg::ilo_instr_t   instr,
  output logic                       instr_ready,
  input  wire logic                  ext_enable,
  input  wire logic [BANK_W-1:0]     bank_select_pointer,
  input  wire logic [PC_W-1:0]       top_of_return_stack,
  input  wire logic                  frame_wr_en,
  input  wire logic [ADDR_W-1:0]     frame_wr_data,
  output logic      [ADDR_W-1:0]     stack_frame_pointer,
  output logic                       pc_load,
  output logic      [PC_W-1:0]       pc_value,
  output ilo_pkg::ilo_mem_t          mem,
  output logic                       flags_hold,
  output logic                       nop_cycle
);
  import ilo_pkg::*;

  ilo_state_t        st_r;
  ilo_state_t        st_nxt;
  logic              take;
  logic              is_sub_ptr;
  logic              is_ret;
  logic              is_frame_sub;
  logic              is_mem_op;
  logic [5:0]        lit_k;
  logic [7:0]        file_addr;
  logic [ADDR_W-1:0] res_addr;
  logic              res_indexed;

  // A word is accepted only outside the dead second cycle of a return.
  assign take        = instr.valid && (st_r.phase == ILO_RUN);
  assign instr_ready = (st_r.phase == ILO_RUN);
  assign lit_k       = instr.word[5:0];
  assign file_addr   = instr.word[7:0];

  // Opcode classes decoded straight from the fetched word.
  assign is_sub_ptr   = (instr.word[15:8] == SUB_PTR_OPC);
  assign is_ret       = is_sub_ptr && (instr.word[7:SEL_LSB] == SEL_RETURN);
  assign is_frame_sub = is_sub_ptr && (instr.word[7:SEL_LSB] == SEL_FRAME);

  // Byte- and bit-oriented groups, all of which carry the access bit in bit 8.
  always_comb begin
    is_mem_op = 1'b0;
    if ((instr.word[15:12] >= 4'h1) && (instr.word[15:12] <= 4'hb)) begin
      is_mem_op = 1'b1;
    end else if (instr.word[15:10] == 6'h01) begin
      is_mem_op = 1'b1;
    end else if (instr.word[15:9] == 7'h01) begin
      is_mem_op = 1'b1;
    end
  end

  // The extension flag itself switches indexed resolution on.
  ilo_addr_resolve u_resolve (
    .ext_enable          (ext_enable),
    .access_sel          (instr.word[ACCESS_BIT]),
    .file_addr           (file_addr),
    .bank_select_pointer (bank_select_pointer),
    .frame_ptr           (st_r.frame_ptr),
    .addr                (res_addr),
    .indexed             (res_indexed)
  );

  // Next-state logic; the decoder's own pointer update wins over a core write in the same cycle.
  always_comb begin
    st_nxt            = st_r;
    st_nxt.pc_load    = 1'b0;
    st_nxt.flags_hold = 1'b0;
    st_nxt.mem        = '0;
    if (frame_wr_en) begin
      st_nxt.frame_ptr = frame_wr_data;
    end
    unique case (st_r.phase)
      ILO_RUN: begin
        if (take && is_ret) begin
          st_nxt.frame_ptr  = st_r.frame_ptr - {6'h00, lit_k};
          st_nxt.pc         = top_of_return_stack;
          st_nxt.pc_load    = 1'b1;
          st_nxt.flags_hold = 1'b1;
          st_nxt.phase      = ILO_RET_NOP;
        end else if (take && is_frame_sub) begin
          st_nxt.frame_ptr  = st_r.frame_ptr - {6'h00, lit_k};
          st_nxt.flags_hold = 1'b1;
        end else if (take && is_mem_op) begin
          st_nxt.mem.addr       = res_addr;
          st_nxt.mem.addr_valid = 1'b1;
          st_nxt.mem.indexed    = res_indexed;
          // Bit-oriented words reuse bit 9 as a bit number, so only byte ops report it.
          st_nxt.mem.dest_f     = (instr.word[15:12] < 4'h7) && instr.word[DEST_BIT];
        end
      end
      ILO_RET_NOP: begin
        // The dead cycle: flags stay held, then normal issue resumes.
        st_nxt.flags_hold = 1'b1;
        st_nxt.phase      = ILO_RUN;
      end
    endcase
  end

  // All state is registered together so outputs come straight from flip-flops.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r           <= '0;
      st_r.phase     <= ILO_RUN;
      st_r.frame_ptr <= FRAME_RST;
      st_r.pc        <= PC_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign stack_frame_pointer = st_r.frame_ptr;
  assign pc_load             = st_r.pc_load;
  assign pc_value            = st_r.pc;
  assign mem                 = st_r.mem;
  assign flags_hold          = st_r.flags_hold;
  assign nop_cycle           = (st_r.phase == ILO_RET_NOP);

  // Helper terms that only the checks below read.
  logic ret_take;
  logic mem_take;
  logic acc0;
  assign ret_take = take && is_ret && !frame_wr_en;
  assign mem_take = take && is_mem_op;
  assign acc0     = !instr.word[ACCESS_BIT];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // The dead cycle shows one cycle after the return's own outputs: nothing may issue from it.
  sequence ret_dead_s;
    !pc_load && !mem.addr_valid && !nop_cycle;
  endsequence

  sequence ret_issue_s;
    pc_load && nop_cycle;
  endsequence

  ret_two_cycles_a: assert property (
      ret_take |=> ret_issue_s ##1 (instr_ready && !nop_cycle))
    else $error("return did not take exactly two cycles");
  ret_dead_cycle_a: assert property (ret_take |=> ret_issue_s ##1 ret_dead_s)
    else $error("return second cycle not idle");
  ret_frame_sub_a: assert property (ret_take |=>
      stack_frame_pointer == $past(st_r.frame_ptr) - {6'h00, $past(lit_k)})
    else $error("frame pointer not reduced by literal");
  ret_pc_load_a: assert property (ret_take |=>
      pc_load && pc_value == $past(top_of_return_stack) ##1 !pc_load)
    else $error("pc not loaded once from return stack");
  ret_flags_a: assert property (ret_take |=> flags_hold [*2])
    else $error("flags not held across return");
  sub_select_a: assert property (take && is_sub_ptr && !is_ret |=> !pc_load)
    else $error("non-return select caused a return");
  index_addr_a: assert property (
      mem_take && ext_enable && acc0 && file_addr <= OFS_MAX |=>
      mem.indexed && mem.addr == $past(st_r.frame_ptr) + {ACC_LO_BANK, $past(file_addr)})
    else $error("indexed address wrong");
  legacy_addr_a: assert property (
      mem_take && !ext_enable && acc0 && file_addr <= OFS_MAX |=>
      !mem.indexed && mem.addr == {ACC_LO_BANK, $past(file_addr)})
    else $error("legacy access address wrong");
  bank_addr_a: assert property (mem_take && !acc0 |=>
      mem.addr == {$past(bank_select_pointer), $past(file_addr)})
    else $error("banked address wrong");
  high_access_a: assert property (mem_take && acc0 && file_addr > OFS_MAX |=>
      !mem.indexed && mem.addr == {ACC_HI_BANK, $past(file_addr)})
    else $error("upper access window remapped");
  zero_frame_a: assert property (
      mem_take && acc0 && st_r.frame_ptr == 12'h000 && file_addr <= OFS_MAX |=>
      mem.addr == {ACC_LO_BANK, $past(file_addr)})
    else $error("zero frame pointer not compatible");
  dest_bit_a: assert property (mem_take && instr.word[15:12] < 4'h7 && ext_enable |=>
      mem.dest_f == $past(instr.word[DEST_BIT]))
    else $error("destination bit altered");
endmodule // ilo_decode

// *** hdl/ilo_pkg.sv ***
package ilo_pkg;
  // Widths of the instruction word, data address, program counter and bank number.
  localparam int unsigned INSTR_W = 16;
  localparam int unsigned ADDR_W  = 12;
  localparam int unsigned PC_W    = 21;
  localparam int unsigned BANK_W  = 4;

  // Upper byte of the subtract_literal_from_pointer opcode and its pointer select codes.
  localparam logic [7:0] SUB_PTR_OPC  = 8'he9;
  localparam logic [1:0] SEL_FRAME    = 2'h2;
  localparam logic [1:0] SEL_RETURN   = 2'h3;

  // Field positions inside the instruction word.
  localparam int unsigned SEL_LSB     = 6;
  localparam int unsigned DEST_BIT    = 9;
  localparam int unsigned ACCESS_BIT  = 8;

  // Largest file address taken as an offset, and the bank of the upper access window.
  localparam logic [7:0] OFS_MAX      = 8'h5f;
  localparam logic [3:0] ACC_LO_BANK  = 4'h0;
  localparam logic [3:0] ACC_HI_BANK  = 4'hf;

  // Reset values.
  localparam logic [ADDR_W-1:0] FRAME_RST = 12'h000;
  localparam logic [PC_W-1:0]   PC_RST    = 21'h000000;

  typedef enum logic [0:0] {
    ILO_RUN     = 1'b0,
    ILO_RET_NOP = 1'b1
  } ilo_phase_t;

  // Instruction word offered by the fetch stage.
  typedef struct packed {
    logic [INSTR_W-1:0] word;
    logic               valid;
  } ilo_instr_t;

  // Resolved data memory operand for byte- and bit-oriented instructions.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              addr_valid;
    logic              dest_f;
    logic              indexed;
  } ilo_mem_t;

  typedef struct packed {
    ilo_phase_t        phase;
    logic [ADDR_W-1:0] frame_ptr;
    logic              pc_load;
    logic [PC_W-1:0]   pc;
    ilo_mem_t          mem;
    logic              flags_hold;
  } ilo_state_t;
endpackage
